// File: src/pmwc_map.svh
// register map, field positions and timing constants of the power-mode and wake control
// Summary of operation
// - idle bit 0, power-down bit 1 select modes
// - idle keeps oscillator, halts core clock
// - idle keeps peripheral clocks running
// - idle retains all processor state
// - idle holds port pins and converter outputs
// - enabled interrupt or reset ends idle
// - power-down stops PLL and core clock
// - oscillator halt bit chooses oscillator in power-down
// - interval counter may run; other peripherals off
// - power-down holds ports, tri-states converter output
// - reset in power-down restores defaults, vector start
// - power cycle restores defaults, vector start
// - interval counter interrupt ends power-down
// - return resumes after the power-down instruction
// - SPI wakes only with its enable set
// - external interrupt 0 wakes only when enabled
// - reset below 2.45 V, then 128 ms hold
// - falling supply keeps reset until below 1 V
`ifndef PMWC_MAP_SVH
`define PMWC_MAP_SVH

// ==========================================================
// register offsets
`define PMWC_OFS_PWR_CTRL 12'h000
`define PMWC_OFS_PLL_CFG 12'h004
`define PMWC_OFS_STATUS 12'h008

// ==========================================================
// power_control_reg fields
`define PMWC_PC_IDLE 0
`define PMWC_PC_PDOWN 1
`define PMWC_PC_SPI_WEN 2
`define PMWC_PC_EXT0_WEN 3

// ==========================================================
// pll_config_reg fields
`define PMWC_PLL_OSC_HALT 0

// ==========================================================
// status register fields
`define PMWC_ST_MODE_LO 0
`define PMWC_ST_MODE_HI 1
`define PMWC_ST_POR_DONE 2
`define PMWC_ST_CAUSE_LO 4
`define PMWC_ST_CAUSE_HI 5

// ==========================================================
// reset values
`define PMWC_RST_BIT 1'b0
`define PMWC_RST_WORD 32'h0000_0000

// ==========================================================
// timing
`define PMWC_CLK_HZ 25000000
`define PMWC_POR_HOLD_MS 128
`define PMWC_MS_PER_S 1000

`endif

// File: src/pmwc_pkg.sv
// types of the power-mode and wake control
`default_nettype none
package pmwc_pkg;
    typedef enum logic [1:0] {
        PMWC_NORMAL,
        PMWC_IDLE,
        PMWC_PDOWN
    } pmwc_mode_t;

    typedef enum logic [1:0] {
        PMWC_CAUSE_NONE,
        PMWC_CAUSE_TIC,
        PMWC_CAUSE_SPI,
        PMWC_CAUSE_EXT0
    } pmwc_cause_t;

    typedef struct packed {
        pmwc_mode_t mode;
        logic idle_req;
        logic pd_req;
        logic spi_wen;
        logic ext0_wen;
        logic osc_halt;
        logic por_done;
        logic [31:0] por_cnt;
        pmwc_cause_t cause;
        logic resume;
        logic [31:0] prdata;
    } pmwc_state_t;
endpackage : pmwc_pkg
`default_nettype wire

// File: src/pmwc_top.sv
// power-mode sequencing, wake-up and power-on reset with an APB register port
//
// Implementation choices: the address map and register access over APB.
`include "pmwc_map.svh"
`default_nettype none
module pmwc_top #(
    parameter int POR_CYCLES = `PMWC_POR_HOLD_MS * (`PMWC_CLK_HZ / `PMWC_MS_PER_S)
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // supply and reset pin
    input wire logic vdd_above_por,
    input wire logic vdd_above_floor,
    input wire logic hw_reset_n,
    // wake sources
    input wire logic irq_pending,
    input wire logic tic_irq,
    input wire logic spi_irq,
    input wire logic ext_irq0_n,
    // clock gates and chip controls
    output logic core_clk_en,
    output logic pll_en,
    output logic osc_en,
    output logic periph_clk_en,
    output logic tic_clk_en,
    output logic port_hold,
    output logic dac_hold,
    output logic dac_tristate,
    output logic chip_reset_n,
    output logic resume_pulse
);
    import pmwc_pkg::*;

    localparam logic [31:0] POR_LAST = 32'(POR_CYCLES - 1);

    pmwc_state_t st_r;
    pmwc_state_t st_nxt;

    logic sys_rst;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic wake_tic;
    logic wake_spi;
    logic wake_ext0;
    logic [31:0] rd_word;

    // ==========================================================
    // apb decode
    assign addr_ok = (paddr == `PMWC_OFS_PWR_CTRL) || (paddr == `PMWC_OFS_PLL_CFG)
        || (paddr == `PMWC_OFS_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata = st_r.prdata;

    // ==========================================================
    // wake qualification
    assign wake_tic = tic_irq;
    assign wake_spi = spi_irq && st_r.spi_wen;
    // level wake; host keeps the line high around entry
    assign wake_ext0 = !ext_irq0_n && st_r.ext0_wen;

    // reset pin clears every register except the power-on timer (por_done, por_cnt); a supply event clears the timer as well
    assign sys_rst = !hw_reset_n || !st_r.por_done;

    always_comb
    begin
        rd_word = `PMWC_RST_WORD;
        case (paddr)
            `PMWC_OFS_PWR_CTRL:
            begin
                rd_word[`PMWC_PC_IDLE] = st_r.idle_req;
                rd_word[`PMWC_PC_PDOWN] = st_r.pd_req;
                rd_word[`PMWC_PC_SPI_WEN] = st_r.spi_wen;
                rd_word[`PMWC_PC_EXT0_WEN] = st_r.ext0_wen;
            end
            `PMWC_OFS_PLL_CFG:
            begin
                rd_word[`PMWC_PLL_OSC_HALT] = st_r.osc_halt;
            end
            `PMWC_OFS_STATUS:
            begin
                rd_word[`PMWC_ST_MODE_HI:`PMWC_ST_MODE_LO] = st_r.mode;
                rd_word[`PMWC_ST_POR_DONE] = st_r.por_done;
                rd_word[`PMWC_ST_CAUSE_HI:`PMWC_ST_CAUSE_LO] = st_r.cause;
            end
            default:
            begin
                rd_word = `PMWC_RST_WORD;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.resume = 1'b0;

        // power-on timer
        if (!vdd_above_por)
        begin
            // hold while below threshold; falling supply stays held down to floor
            st_nxt.por_done = 1'b0;
            st_nxt.por_cnt = `PMWC_RST_WORD;
            if (!vdd_above_floor)
            begin
                st_nxt.por_cnt = `PMWC_RST_WORD;
            end
        end
        else if (!st_r.por_done)
        begin
            if (st_r.por_cnt == POR_LAST)
            begin
                st_nxt.por_done = 1'b1;
            end
            else
            begin
                st_nxt.por_cnt = st_r.por_cnt + 32'h0000_0001;
            end
        end

        if (sys_rst)
        begin
            // defaults; processor restarts at its vector on release
            st_nxt.mode = PMWC_NORMAL;
            st_nxt.idle_req = `PMWC_RST_BIT;
            st_nxt.pd_req = `PMWC_RST_BIT;
            st_nxt.spi_wen = `PMWC_RST_BIT;
            st_nxt.ext0_wen = `PMWC_RST_BIT;
            st_nxt.osc_halt = `PMWC_RST_BIT;
            st_nxt.cause = PMWC_CAUSE_NONE;
            st_nxt.prdata = `PMWC_RST_WORD;
        end
        else
        begin
            if (rd_setup)
            begin
                st_nxt.prdata = rd_word;
            end
            if (wr_en)
            begin
                case (paddr)
                    `PMWC_OFS_PWR_CTRL:
                    begin
                        st_nxt.idle_req = pwdata[`PMWC_PC_IDLE];
                        st_nxt.pd_req = pwdata[`PMWC_PC_PDOWN];
                        st_nxt.spi_wen = pwdata[`PMWC_PC_SPI_WEN];
                        st_nxt.ext0_wen = pwdata[`PMWC_PC_EXT0_WEN];
                    end
                    `PMWC_OFS_PLL_CFG:
                    begin
                        st_nxt.osc_halt = pwdata[`PMWC_PLL_OSC_HALT];
                    end
                    default:
                    begin
                        st_nxt.prdata = st_nxt.prdata;
                    end
                endcase
            end

            case (st_r.mode)
                PMWC_NORMAL:
                begin
                    // power-down takes precedence over idle
                    if (st_r.pd_req)
                    begin
                        st_nxt.mode = PMWC_PDOWN;
                    end
                    else if (st_r.idle_req)
                    begin
                        st_nxt.mode = PMWC_IDLE;
                    end
                end
                PMWC_IDLE:
                begin
                    if (irq_pending)
                    begin
                        st_nxt.mode = PMWC_NORMAL;
                        st_nxt.idle_req = 1'b0;
                        st_nxt.resume = 1'b1;
                    end
                end
                PMWC_PDOWN:
                begin
                    if (wake_tic || wake_spi || wake_ext0)
                    begin
                        st_nxt.mode = PMWC_NORMAL;
                        st_nxt.pd_req = 1'b0;
                        st_nxt.idle_req = 1'b0;
                        // core resumes where it stopped; isr return continues
                        st_nxt.resume = 1'b1;
                        if (wake_ext0)
                        begin
                            st_nxt.cause = PMWC_CAUSE_EXT0;
                        end
                        else if (wake_tic)
                        begin
                            st_nxt.cause = PMWC_CAUSE_TIC;
                        end
                        else
                        begin
                            st_nxt.cause = PMWC_CAUSE_SPI;
                        end
                    end
                end
                default:
                begin
                    st_nxt.mode = PMWC_NORMAL;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // clock gates and pin controls
    always_comb
    begin
        // core clock gated only; processor registers keep their contents
        core_clk_en = (st_r.mode == PMWC_NORMAL) && st_r.por_done;
        pll_en = (st_r.mode != PMWC_PDOWN);
        // oscillator runs in idle, optional in power-down
        osc_en = !((st_r.mode == PMWC_PDOWN) && st_r.osc_halt);
        periph_clk_en = (st_r.mode != PMWC_PDOWN);
        tic_clk_en = osc_en;
        port_hold = (st_r.mode != PMWC_NORMAL);
        dac_hold = (st_r.mode == PMWC_IDLE);
        dac_tristate = (st_r.mode == PMWC_PDOWN);
        chip_reset_n = !sys_rst;
        resume_pulse = st_r.resume;
    end
endmodule : pmwc_top
`default_nettype wire

// File: verif/pmwc_properties.sv
// assertions of the power-mode and wake control, bound to its top module
`default_nettype none
module pmwc_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // supply, reset pin, wake
    input wire logic vdd_above_por,
    input wire logic hw_reset_n,
    input wire logic irq_pending,
    input wire logic tic_irq,
    // controls
    input wire logic core_clk_en,
    input wire logic pll_en,
    input wire logic osc_en,
    input wire logic periph_clk_en,
    input wire logic tic_clk_en,
    input wire logic port_hold,
    input wire logic dac_hold,
    input wire logic dac_tristate,
    input wire logic chip_reset_n,
    input wire logic resume_pulse
);
    // ==========================================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_resumed;
        resume_pulse && core_clk_en && !port_hold ##1 !resume_pulse;
    endsequence
    property p_pd_gates;
        dac_tristate |-> !pll_en && !core_clk_en && !periph_clk_en && port_hold && !dac_hold;
    endproperty
    property p_idle_gates;
        dac_hold |-> pll_en && osc_en && periph_clk_en && !core_clk_en && port_hold;
    endproperty
    property p_tic_osc;
        tic_clk_en == osc_en;
    endproperty
    property p_tic_wake;
        dac_tristate && tic_irq && clk_en && hw_reset_n && vdd_above_por |=> s_resumed;
    endproperty
    property p_idle_wake;
        dac_hold && irq_pending && clk_en && hw_reset_n && vdd_above_por |=> s_resumed;
    endproperty
    property p_pin_reset;
        !hw_reset_n |-> !chip_reset_n;
    endproperty
    property p_supply;
        !vdd_above_por && clk_en |=> !chip_reset_n;
    endproperty
    property p_apb;
        psel && penable |-> pready && (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}));
    endproperty
    a_pd_gates: assert property (p_pd_gates) else $error("power-down gating wrong");
    a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");
    a_tic_osc: assert property (p_tic_osc) else $error("interval clock gate wrong");
    a_tic_wake: assert property (p_tic_wake) else $error("no interval wake");
    a_idle_wake: assert property (p_idle_wake) else $error("no idle wake");
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
    a_supply: assert property (p_supply) else $error("low supply not held");
    a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule : pmwc_properties
bind pmwc_top pmwc_properties u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .vdd_above_por(vdd_above_por), .hw_reset_n(hw_reset_n), .irq_pending(irq_pending),
    .tic_irq(tic_irq), .core_clk_en(core_clk_en), .pll_en(pll_en), .osc_en(osc_en),
    .periph_clk_en(periph_clk_en), .tic_clk_en(tic_clk_en), .port_hold(port_hold),
    .dac_hold(dac_hold), .dac_tristate(dac_tristate), .chip_reset_n(chip_reset_n),
    .resume_pulse(resume_pulse));
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the power-mode and wake control
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, er, vdd_above_por = 1'h1, vdd_above_floor = 1'h1;
    logic hw_reset_n = 1'h1, irq_pending = 1'h0, tic_irq = 1'h0, spi_irq = 1'h0;
    logic ext_irq0_n = 1'h1, core_clk_en, pll_en, osc_en, periph_clk_en, tic_clk_en;
    logic port_hold, dac_hold, dac_tristate, chip_reset_n, resume_pulse;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int mismatches = 0, samples_checked = 0;
    wire [7:0] gates = {core_clk_en, pll_en, osc_en, periph_clk_en, port_hold, dac_hold,
        dac_tristate, tic_clk_en};
    always #20 pclk = ~pclk;
    pmwc_top #(.POR_CYCLES(8)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vdd_above_por(vdd_above_por),
        .vdd_above_floor(vdd_above_floor), .hw_reset_n(hw_reset_n),
        .irq_pending(irq_pending), .tic_irq(tic_irq), .spi_irq(spi_irq),
        .ext_irq0_n(ext_irq0_n), .core_clk_en(core_clk_en), .pll_en(pll_en), .osc_en(osc_en),
        .periph_clk_en(periph_clk_en), .tic_clk_en(tic_clk_en), .port_hold(port_hold),
        .dac_hold(dac_hold), .dac_tristate(dac_tristate), .chip_reset_n(chip_reset_n),
        .resume_pulse(resume_pulse));
    // ==========================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic src(input int s, input logic on);
        case (s)
            0: tic_irq <= on;
            1: spi_irq <= on;
            2: ext_irq0_n <= !on;
            default: irq_pending <= on;
        endcase
    endtask : src
    // mode entry, one wake attempt, then forced exit if it did not wake
    task automatic run(input logic [31:0] pc, input int s, input logic wk,
        input logic [1:0] cs, input logic [7:0] outs);
        apb(1'h1, 12'h000, pc);
        apb(1'h0, 12'h008, 32'h0);
        chk("mode", rd[1:0], pc[1] ? 32'h2 : 32'h1);
        @(negedge pclk);
        chk("gates", gates, outs);
        @(posedge pclk);
        src(s, 1'h1);
        @(posedge pclk);
        src(s, 1'h0);
        @(negedge pclk);
        chk("wake", resume_pulse, wk);
        if (!wk)
        begin
            @(posedge pclk);
            tic_irq <= 1'h1;
            @(posedge pclk);
            tic_irq <= 1'h0;
        end
        apb(1'h0, 12'h008, 32'h0);
        if (wk && s < 3)
            chk("cause", rd[5:4], cs);
        apb(1'h0, 12'h000, 32'h0);
        chk("ctrl", rd, pc & 32'hc);
    endtask : run
    // ==========================================================
    // sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        chk("por_hold", chip_reset_n, 1'h0);
        repeat (20) @(posedge pclk);
        chk("por_done", chip_reset_n, 1'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk("pll_rst", rd, 32'h0);
        apb(1'h1, 12'h008, 32'h3);
        apb(1'h0, 12'h008, 32'h0);
        chk("status", rd, 32'h4);
        apb(1'h0, 12'h00c, 32'h0);
        chk("slverr", er, 1'h1);
        // enable low freezes state: a write made then is lost
        clk_en <= 1'h0;
        apb(1'h1, 12'h000, 32'h2);
        clk_en <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk("frozen", rd, 32'h0);
        apb(1'h1, 12'h004, 32'h0);
        run(32'h2, 0, 1'h1, 2'h1, 8'h2b);
        apb(1'h1, 12'h004, 32'h1);
        run(32'h2, 0, 1'h1, 2'h1, 8'h0a);
        run(32'h2, 1, 1'h0, 2'h0, 8'h0a);
        run(32'h6, 1, 1'h1, 2'h2, 8'h0a);
        run(32'h2, 2, 1'h0, 2'h0, 8'h0a);
        run(32'ha, 2, 1'h1, 2'h3, 8'h0a);
        run(32'h1, 3, 1'h1, 2'h0, 8'h7d);
        run(32'h3, 0, 1'h1, 2'h1, 8'h0a);
        apb(1'h1, 12'h000, 32'h6);
        @(posedge pclk);
        hw_reset_n <= 1'h0;
        @(negedge pclk);
        chk("pin_rst", chip_reset_n, 1'h0);
        @(posedge pclk);
        hw_reset_n <= 1'h1;
        @(negedge pclk);
        chk("pd_left", gates, 8'hf1);
        apb(1'h0, 12'h004, 32'h0);
        chk("pll_def", rd, 32'h0);
        apb(1'h1, 12'h000, 32'hc);
        @(posedge pclk);
        vdd_above_por <= 1'h0;
        @(posedge pclk);
        vdd_above_floor <= 1'h0;
        repeat (3) @(posedge pclk);
        vdd_above_floor <= 1'h1;
        @(negedge pclk);
        chk("supply_low", chip_reset_n, 1'h0);
        @(posedge pclk);
        vdd_above_por <= 1'h1;
        repeat (20) @(posedge pclk);
        chk("supply_up", chip_reset_n, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk("pc_def", rd, 32'h0);
        final_report();
    end
    initial
    begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        final_report();
    end
endmodule : tb
`default_nettype wire
